// ==== src/bcs_brake_check.sv ====
// Brake-check status flags, mirrors, speed supervision selection and limits
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/100ps
module bcs_brake_check (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire bcs_pkg::bcs_events_t i_events,
    input wire logic i_invalid_tool,
    input wire logic i_sync_state_flag,
    input wire logic i_override_supervision,
    input wire bcs_pkg::bcs_speeds_t i_speeds,
    input wire logic [bcs_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output bcs_pkg::bcs_flags_t o_flags,
    output bcs_pkg::bcs_flags_t o_mirror,
    output logic [15:0] o_msg_code,
    output logic o_msg_pulse,
    output logic o_request_msg_pulse,
    output bcs_pkg::bcs_points_t o_points,
    output logic o_speed_limited,
    output logic o_overspeed
);
    import bcs_pkg::*;

    logic [5:0] prim;
    logic [5:0] mirror;
    logic [5:0] pending;
    logic [7:0] lag_cnt;
    logic [7:0] mirror_lag;
    logic limit_en;
    logic prew_snap;
    logic first_test;
    logic request_seen;
    bcs_event_t ev;
    logic [5:0] p_set;
    logic [5:0] p_clr;
    logic [5:0] m_set;
    logic [5:0] m_clr;
    logic [5:0] next_prim;
    logic [5:0] next_mirror;
    logic [5:0] next_pending;
    logic [15:0] next_msg;
    bcs_points_t next_points;
    logic next_overspeed;
    logic [NUM_AXES-1:0] axis_over;

    // Event selection, one per cycle, most decisive outcome first
    always_comb begin
        if (i_events.config_loaded) begin
            ev = EV_CONFIG;
        end else if (i_events.failed) begin
            ev = EV_FAIL;
        end else if (i_events.warning) begin
            ev = EV_WARN;
        end else if (i_events.passed) begin
            ev = EV_PASS;
        end else if (i_events.pointer_to_main) begin
            ev = EV_MAIN;
        end else if (i_events.interrupted) begin
            ev = EV_INTR;
        end else if (i_events.start) begin
            ev = EV_START;
        end else if (i_events.interval_elapsed) begin
            ev = EV_INTERVAL;
        end else if (i_events.prewarn_expired) begin
            ev = EV_PREWARN;
        end else begin
            ev = EV_NONE;
        end
    end

    // Set and clear masks for primaries and mirrors
    always_comb begin
        p_set = 6'h00;
        p_clr = 6'h00;
        m_set = 6'h00;
        m_clr = 6'h00;
        unique case (ev)
            EV_CONFIG: begin
                p_set = 6'h01 << FL_REQUEST;
                p_clr = ~p_set;
                m_set = p_set;
                m_clr = p_clr;
            end
            EV_FAIL: begin
                p_set = (6'h01 << FL_REQUEST) | (6'h01 << FL_FAILED);
                p_clr = (6'h01 << FL_PASSED) | (6'h01 << FL_WARNING) | (6'h01 << FL_ACTIVE);
                m_set = p_set;
                m_clr = p_clr;
            end
            EV_WARN: begin
                p_set = 6'h01 << FL_WARNING;
                p_clr = ~p_set;
                m_set = p_set;
                m_clr = p_clr;
            end
            EV_PASS: begin
                p_set = 6'h01 << FL_PASSED;
                p_clr = ~p_set;
                m_set = p_set;
                m_clr = p_clr;
            end
            EV_MAIN: begin
                p_set = 6'h01 << FL_REQUEST;
                p_clr = (6'h01 << FL_PASSED) | (6'h01 << FL_ACTIVE);
                m_clr = p_clr;
            end
            EV_INTR: begin
                m_set = 6'h01 << FL_REQUEST;
            end
            EV_START: begin
                p_set = 6'h01 << FL_ACTIVE;
                p_clr = (6'h01 << FL_PASSED) | (6'h01 << FL_FAILED) | (6'h01 << FL_WARNING);
                m_set = 6'h01 << FL_ACTIVE;
                m_clr = 6'h01 << FL_PASSED;
            end
            EV_INTERVAL: begin
                p_set = (6'h01 << FL_REQUEST) | (6'h01 << FL_PREWARN);
                m_set = p_set;
            end
            EV_PREWARN: begin
                p_set = 6'h01 << FL_PREWARN;
                m_set = p_set;
            end
            EV_NONE: begin
                p_set = 6'h00;
            end
        endcase
    end

    // Next flag values; a failed test restores the pre-test prewarning
    always_comb begin
        next_prim = (prim & ~p_clr) | p_set;
        next_mirror = mirror;
        if (ev == EV_FAIL) begin
            next_prim[FL_PREWARN] = prew_snap;
        end
        // Lagged copy of primaries not written explicitly this cycle
        if (pending != 6'h00 && lag_cnt >= mirror_lag) begin
            next_mirror = (mirror & ~pending) | (prim & pending);
        end
        next_mirror = (next_mirror & ~m_clr) | m_set;
        if (ev == EV_FAIL) begin
            next_mirror[FL_PREWARN] = prew_snap;
        end
        next_pending = pending;
        if (pending != 6'h00 && lag_cnt >= mirror_lag) begin
            next_pending = 6'h00;
        end
        next_pending = (next_pending | (next_prim ^ prim)) & ~(m_set | m_clr);
        if (ev == EV_FAIL) begin
            next_pending[FL_PREWARN] = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prim <= FLAGS_RST;
            mirror <= FLAGS_RST;
            pending <= 6'h00;
        end else begin
            prim <= next_prim;
            mirror <= next_mirror;
            pending <= next_pending;
        end
    end

    // Lag timer restarts whenever new bits start waiting
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lag_cnt <= 8'h00;
        end else if (next_pending == 6'h00 || (next_pending & ~pending) != 6'h00) begin
            lag_cnt <= 8'h00;
        end else if (lag_cnt != 8'hff) begin
            lag_cnt <= lag_cnt + 8'h01;
        end
    end

    // Prewarning level seen when the test began
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prew_snap <= 1'b0;
            first_test <= 1'b0;
        end else begin
            if (ev == EV_START) begin
                prew_snap <= prim[FL_PREWARN];
            end else if (!prim[FL_ACTIVE]) begin
                // No test running: an error outcome leaves prewarning as it stands
                prew_snap <= next_prim[FL_PREWARN];
            end
            if (ev == EV_CONFIG) begin
                first_test <= 1'b1;
            end else if (ev == EV_START) begin
                first_test <= 1'b0;
            end
        end
    end

    assign o_flags = prim;
    assign o_mirror = mirror;
    assign o_speed_limited = limit_en & prim[FL_REQUEST];

    // Prioritised message choice
    always_comb begin
        if (i_invalid_tool) begin
            next_msg = MSG_TOOL_CHANGE;
        end else if (!i_sync_state_flag) begin
            next_msg = MSG_UNSYNC;
        end else if (i_override_supervision) begin
            next_msg = MSG_OVERRIDE;
        end else begin
            next_msg = MSG_NONE;
        end
    end

    // Supervised points are the union of all active supervisions
    always_comb begin
        next_points.tool_point = i_invalid_tool | !i_sync_state_flag | i_override_supervision
            | prim[FL_REQUEST];
        next_points.flange = i_invalid_tool | !i_sync_state_flag | i_override_supervision;
        next_points.elbow = next_points.flange;
        next_points.axes = !i_sync_state_flag;
    end

    genvar ax;
    generate
        for (ax = 0; ax < NUM_AXES; ax++) begin : g_axis
            if (ax < AXIS_HIGH_FIRST) begin : g_low
                assign axis_over[ax] = i_speeds.axis[ax] >= LIM_AXIS_LOW_DPS;
            end else begin : g_high
                assign axis_over[ax] = i_speeds.axis[ax] >= LIM_AXIS_HIGH_DPS;
            end
        end
    endgenerate

    always_comb begin
        next_overspeed = (next_points.tool_point && i_speeds.tool_point >= LIM_POINT_MMPS)
            || (next_points.flange && i_speeds.flange >= LIM_POINT_MMPS)
            || (next_points.elbow && i_speeds.elbow >= LIM_POINT_MMPS)
            || (next_points.axes && axis_over != '0);
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_msg_code <= MSG_NONE;
            o_msg_pulse <= 1'b0;
            o_points <= '0;
            o_overspeed <= 1'b0;
        end else begin
            o_msg_code <= next_msg;
            o_msg_pulse <= (next_msg != o_msg_code) && (next_msg != MSG_NONE);
            o_points <= next_points;
            o_overspeed <= next_overspeed;
        end
    end

    // Brake-request message stands apart from the priority choice
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            request_seen <= 1'b0;
            o_request_msg_pulse <= 1'b0;
        end else begin
            request_seen <= prim[FL_REQUEST];
            o_request_msg_pulse <= prim[FL_REQUEST] & ~request_seen;
        end
    end

    // Register port: writes
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            limit_en <= CTRL_LIMIT_EN_RST;
            mirror_lag <= MIRROR_LAG_RST;
        end else if (i_wr && i_addr == REG_CTRL) begin
            limit_en <= i_wdata[CTRL_LIMIT_EN];
            mirror_lag <= i_wdata[CTRL_LAG_LSB +: 8];
        end
    end

    // Register port: reads answer in the next cycle only
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            o_rdata <= 32'h0000_0000;
            unique case (i_addr)
                REG_CTRL: begin
                    o_rdata[CTRL_LIMIT_EN] <= limit_en;
                    o_rdata[CTRL_LAG_LSB +: 8] <= mirror_lag;
                end
                REG_FLAGS: begin
                    o_rdata[5:0] <= prim;
                    o_rdata[FLAGS_MIRROR_LSB +: 6] <= mirror;
                end
                REG_SUPERV: begin
                    o_rdata[15:0] <= o_msg_code;
                    o_rdata[SUP_POINTS_LSB +: 4] <= o_points;
                    o_rdata[SUP_OVERSPEED] <= o_overspeed;
                    o_rdata[SUP_LIMITED] <= o_speed_limited;
                end
                default: begin
                    o_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // Checker helper: the last test began with prewarning clear and no outcome or configuration has followed
    logic prew_clear_run;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prew_clear_run <= 1'b0;
        end else if (ev == EV_START) begin
            prew_clear_run <= !prim[FL_PREWARN];
        end else if (ev == EV_CONFIG || ev == EV_PASS || ev == EV_WARN || ev == EV_FAIL) begin
            prew_clear_run <= 1'b0;
        end
    end

    // Checker helper: request mirror held high by an interruption
    logic intr_req;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            intr_req <= 1'b0;
        end else if (ev == EV_INTR) begin
            intr_req <= 1'b1;
        end else if (mirror[FL_REQUEST] == prim[FL_REQUEST]) begin
            intr_req <= 1'b0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_pass_outcome: assert property (ev == EV_PASS |=> prim == 6'h20 && mirror == 6'h20)
        else $error("pass outcome flags wrong");

    a_warn_outcome: assert property (ev == EV_WARN |=> prim == 6'h04 && mirror == 6'h04)
        else $error("warning outcome flags wrong");

    a_fail_outcome: assert property (ev == EV_FAIL |=>
        prim[5:1] == 5'b01100 && mirror[5:1] == 5'b01100 && o_speed_limited == limit_en)
        else $error("error outcome flags wrong");

    a_fail_prewarn: assert property (ev == EV_FAIL && prew_clear_run
        |=> !prim[FL_PREWARN] && !mirror[FL_PREWARN])
        else $error("prewarning not restored after error");

    a_start_flags: assert property (ev == EV_START |=>
        prim[FL_ACTIVE] && !prim[FL_PASSED] && !prim[FL_FAILED] && !prim[FL_WARNING]
        && mirror[FL_ACTIVE] && !mirror[FL_PASSED])
        else $error("start flags wrong");

    a_intr_mirror: assert property (ev == EV_INTR |=>
        mirror[FL_REQUEST] && prim == $past(prim))
        else $error("interruption handling wrong");

    a_config_flags: assert property (ev == EV_CONFIG |=>
        prim == 6'h10 && mirror == 6'h10 && first_test)
        else $error("configuration flags wrong");

    a_mirror_follows: assert property (
        (ev == EV_NONE && mirror_lag < 8'd8)[*8] |->
        ((mirror ^ prim) & ~({5'h00, intr_req} << FL_REQUEST)) == 6'h00 || pending != 6'h00)
        else $error("mirror did not follow primary");

    a_msg_priority: assert property (i_invalid_tool |=> o_msg_code == MSG_TOOL_CHANGE)
        else $error("tool change message not chosen");

    a_unsync_axes: assert property (!i_sync_state_flag && i_speeds.axis[0] >= LIM_AXIS_LOW_DPS
        |=> o_overspeed && o_points.axes)
        else $error("axis speed not supervised while unsynchronised");

    a_tool_no_axes: assert property (i_invalid_tool && i_sync_state_flag
        |=> !o_points.axes && o_points.flange)
        else $error("tool change supervision points wrong");

    c_full_test: cover property (ev == EV_START ##[1:50] ev == EV_PASS);
    c_fail_test: cover property (ev == EV_START ##[1:50] ev == EV_FAIL);
    c_lagged_copy: cover property (pending != 6'h00 ##[1:20] pending == 6'h00);
    c_both_msgs: cover property (o_msg_pulse && o_request_msg_pulse);

endmodule

// ==== src/bcs_pkg.sv ====
// Constants, types and register map of the brake-check status and speed limit block
package bcs_pkg;

    localparam int SPEED_W = 16;
    localparam int NUM_AXES = 6;

    // Flag bit positions inside the six-bit flag word
    localparam int FL_PASSED = 5;
    localparam int FL_REQUEST = 4;
    localparam int FL_FAILED = 3;
    localparam int FL_WARNING = 2;
    localparam int FL_ACTIVE = 1;
    localparam int FL_PREWARN = 0;

    // Message codes
    localparam logic [15:0] MSG_NONE = 16'h0000;
    localparam logic [15:0] MSG_TOOL_CHANGE = 16'd20494;
    localparam logic [15:0] MSG_UNSYNC = 16'd20487;
    localparam logic [15:0] MSG_OVERRIDE = 16'd20490;
    localparam logic [15:0] MSG_BRAKE_REQUEST = 16'd20450;

    // Reduced speed limits
    localparam logic [SPEED_W-1:0] LIM_POINT_MMPS = 16'd250;
    localparam logic [SPEED_W-1:0] LIM_AXIS_LOW_DPS = 16'd20;
    localparam logic [SPEED_W-1:0] LIM_AXIS_HIGH_DPS = 16'd38;
    localparam int AXIS_HIGH_FIRST = 3;

    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SUPERV = 8'h08;

    // Field positions
    localparam int CTRL_LIMIT_EN = 0;
    localparam int CTRL_LAG_LSB = 8;
    localparam int FLAGS_MIRROR_LSB = 8;
    localparam int SUP_POINTS_LSB = 16;
    localparam int SUP_OVERSPEED = 24;
    localparam int SUP_LIMITED = 25;

    // Reset values
    localparam logic CTRL_LIMIT_EN_RST = 1'b1;
    localparam logic [7:0] MIRROR_LAG_RST = 8'h04;
    localparam logic [5:0] FLAGS_RST = 6'h00;

    typedef struct packed {
        logic passed;
        logic request;
        logic failed;
        logic warning;
        logic active;
        logic prewarning;
    } bcs_flags_t;

    typedef struct packed {
        logic [SPEED_W-1:0] tool_point;
        logic [SPEED_W-1:0] flange;
        logic [SPEED_W-1:0] elbow;
        logic [NUM_AXES-1:0][SPEED_W-1:0] axis;
    } bcs_speeds_t;

    typedef struct packed {
        logic tool_point;
        logic flange;
        logic elbow;
        logic axes;
    } bcs_points_t;

    typedef struct packed {
        logic start;
        logic passed;
        logic warning;
        logic failed;
        logic interrupted;
        logic pointer_to_main;
        logic config_loaded;
        logic prewarn_expired;
        logic interval_elapsed;
    } bcs_events_t;

    typedef enum logic [9:0] {
        EV_NONE = 10'b00_0000_0001,
        EV_CONFIG = 10'b00_0000_0010,
        EV_FAIL = 10'b00_0000_0100,
        EV_WARN = 10'b00_0000_1000,
        EV_PASS = 10'b00_0001_0000,
        EV_MAIN = 10'b00_0010_0000,
        EV_INTR = 10'b00_0100_0000,
        EV_START = 10'b00_1000_0000,
        EV_INTERVAL = 10'b01_0000_0000,
        EV_PREWARN = 10'b10_0000_0000
    } bcs_event_t;

endpackage

// ==== test/bcs_brake_check_bench.sv ====
// Self-checking bench for the brake-check status and speed limit block
`timescale 1ns/100ps
module bcs_brake_check_bench;
    import bcs_pkg::*;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic go = 1'b0;
    logic tool_bad = 1'b0;
    logic synced = 1'b1;
    logic override_supervision = 1'b0;
    logic rd_pend = 1'b0;
    logic limit_en = 1'b1;
    logic prew_cap = 1'b0;
    logic test_due, busy, o_msg_pulse, o_req_pulse, o_limited, o_overspeed;
    logic [3:0] delay = 4'h0;
    logic [7:0] addr = 8'h00;
    logic [15:0] o_msg_code;
    logic [31:0] wdata = 32'h0;
    logic [31:0] o_rdata;
    logic [31:0] exp_q[$];
    bcs_speeds_t speeds = '0;
    bcs_events_t events;
    bcs_flags_t o_flags, o_mirror;
    bcs_flags_t exp_f = '0;
    bcs_flags_t exp_m = '0;
    bcs_flags_t pend = '0;
    bcs_points_t o_points;
    bcs_event_t kind = EV_NONE;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int lag = 4;
    int rises = 0;
    int pulses = 0;
    int msg_pulses = 0;
    int msg_exp = 0;
    logic [15:0] last_msg = 16'h0;
    logic [31:0] sup_now;
    bcs_event_t seq[16] = '{EV_CONFIG, EV_START, EV_PREWARN, EV_FAIL, EV_START, EV_PASS,
        EV_START, EV_INTR, EV_MAIN, EV_START, EV_WARN, EV_INTERVAL, EV_START, EV_INTR,
        EV_FAIL, EV_CONFIG};

    bcs_brake_check dut (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_events(events), .i_invalid_tool(tool_bad),
        .i_sync_state_flag(synced), .i_override_supervision(override_supervision), .i_speeds(speeds),
        .i_addr(addr), .i_wdata(wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_flags(o_flags), .o_mirror(o_mirror), .o_msg_code(o_msg_code),
        .o_msg_pulse(o_msg_pulse), .o_request_msg_pulse(o_req_pulse), .o_points(o_points),
        .o_speed_limited(o_limited), .o_overspeed(o_overspeed)
    );

    bcs_robot_model robot (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_go(go), .i_kind(kind), .i_delay(delay),
        .i_flags(o_flags), .o_events(events), .o_busy(busy), .o_test_due(test_due)
    );

    initial begin
        forever #2 i_clk = ~i_clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge i_clk) begin
        if (rd_pend) begin
            chk(o_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
        end
        if (o_req_pulse === 1'b1) begin
            pulses++;
        end
        if (o_msg_pulse === 1'b1) begin
            msg_pulses++;
        end
        rd_pend <= i_rd;
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge i_clk);
        i_rd <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    function automatic logic [31:0] fl();
        return {18'h0, exp_m, 2'h0, exp_f};
    endfunction

    function automatic logic [31:0] exp_sup();
        logic us;
        logic any;
        logic os;
        logic [3:0] pts;
        logic [15:0] lim;
        us = !synced;
        any = tool_bad | us | override_supervision;
        pts = {any | exp_f.request, any, any, us};
        os = pts[3] && speeds.tool_point >= LIM_POINT_MMPS;
        os |= any && (speeds.flange >= LIM_POINT_MMPS || speeds.elbow >= LIM_POINT_MMPS);
        for (int k = 0; k < NUM_AXES; k++) begin
            lim = k < AXIS_HIGH_FIRST ? LIM_AXIS_LOW_DPS : LIM_AXIS_HIGH_DPS;
            os |= us && speeds.axis[k] >= lim;
        end
        return {6'h0, limit_en & exp_f.request, os, 4'h0, pts,
            tool_bad ? MSG_TOOL_CHANGE : us ? MSG_UNSYNC : override_supervision ? MSG_OVERRIDE : MSG_NONE};
    endfunction

    task automatic set_spd(input logic wide);
        logic [NUM_AXES-1:0][SPEED_W-1:0] ax;
        for (int k = 0; k < NUM_AXES; k++) begin
            ax[k] = 16'($urandom_range(0, wide ? 45 : 19));
        end
        speeds.axis <= ax;
        speeds.tool_point <= wide ? LIM_POINT_MMPS : 16'($urandom_range(0, 249));
        speeds.flange <= 16'($urandom_range(0, wide ? 300 : 249));
        speeds.elbow <= 16'($urandom_range(0, wide ? 300 : 249));
    endtask

    // Partner issues the step; flags and unsettled mirrors checked at once, then after lag
    task automatic ev(input bcs_event_t k);
        bcs_flags_t old;
        logic [5:0] mset;
        logic [5:0] mval;
        int n;
        old = exp_f;
        @(posedge i_clk);
        go <= 1'b1;
        kind <= k;
        delay <= 4'($urandom_range(0, 15));
        @(posedge i_clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while (busy && n < 40);
        if (k == EV_START || !exp_f.active) prew_cap = exp_f.prewarning;
        case (k)
            EV_START: {exp_f, mset, mval} = {exp_f & 6'h11 | 6'h02, 6'h22, 6'h02};
            EV_PASS: {exp_f, mset, mval} = {6'h20, 6'h3f, 6'h20};
            EV_WARN: {exp_f, mset, mval} = {6'h04, 6'h3f, 6'h04};
            EV_FAIL: {exp_f, mset, mval} = {6'h18 | prew_cap, 6'h3f, 6'h18 | prew_cap};
            EV_INTR: {exp_f, mset, mval} = {exp_f, 6'h10, 6'h10};
            EV_MAIN: {exp_f, mset, mval} = {exp_f & 6'h1d | 6'h10, 6'h22, 6'h00};
            EV_CONFIG: {exp_f, mset, mval} = {6'h10, 6'h3f, 6'h10};
            EV_PREWARN: {exp_f, mset, mval} = {exp_f | 6'h01, 6'h01, 6'h01};
            default: {exp_f, mset, mval} = {exp_f | 6'h11, 6'h11, 6'h11};
        endcase
        if (!old.request && exp_f.request) rises++;
        pend = (pend | old ^ exp_f) & ~mset;
        exp_m = exp_m & ~mset | mval;
        rd(REG_FLAGS, fl());
        repeat (lag + 4) @(posedge i_clk);
        exp_m = exp_m & ~pend | exp_f & pend;
        pend = '0;
        rd(REG_FLAGS, fl());
        chk({18'h0, o_mirror, 2'h0, o_flags}, fl());
        rd(REG_SUPERV, exp_sup());
    endtask

    initial begin
        void'($urandom(32'heb5c));
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        rd(REG_CTRL, {16'h0, MIRROR_LAG_RST, 7'h0, CTRL_LIMIT_EN_RST});
        rd(REG_FLAGS, 32'h0);
        rd(8'h0c, 32'h0);
        wr(REG_FLAGS, 32'hffff_ffff);
        wr(8'h0c, 32'hffff_ffff);
        rd(REG_FLAGS, 32'h0);
        rd(REG_CTRL, {16'h0, MIRROR_LAG_RST, 7'h0, CTRL_LIMIT_EN_RST});
        $display("test registers done");
        for (int i = 0; i < 16; i++) begin
            ev(seq[i]);
        end
        chk({31'h0, test_due}, 32'h1);
        $display("test flag sequence done");
        lag = $urandom_range(3, 8);
        limit_en = 1'b0;
        wr(REG_CTRL, {16'h0, 8'(lag), 7'h0, limit_en});
        rd(REG_CTRL, {16'h0, 8'(lag), 7'h0, limit_en});
        ev(EV_FAIL);
        ev(EV_START);
        ev(EV_PASS);
        limit_en = 1'b1;
        wr(REG_CTRL, {16'h0, 8'(lag), 7'h0, limit_en});
        $display("test limit option done");
        for (int c = 0; c < 16; c++) begin
            tool_bad <= c[0];
            synced <= !c[1];
            override_supervision <= c[2];
            set_spd(c[3]);
            repeat (3) @(posedge i_clk);
            sup_now = exp_sup();
            rd(REG_SUPERV, sup_now);
            chk({6'h0, o_limited, o_overspeed, 4'h0, o_points, o_msg_code}, sup_now);
            if (sup_now[15:0] != last_msg && sup_now[15:0] != MSG_NONE) msg_exp++;
            last_msg = sup_now[15:0];
        end
        repeat (4) @(posedge i_clk);
        chk(32'(pulses), 32'(rises));
        chk(32'(msg_pulses), 32'(msg_exp));
        $display("test supervision priority done");
        wrap_up();
    end
endmodule

// ==== test/bcs_robot_model.sv ====
// Behavioural main computer that issues brake-test steps after a chosen delay
`timescale 1ns/100ps
module bcs_robot_model (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_go,
    input wire bcs_pkg::bcs_event_t i_kind,
    input wire logic [3:0] i_delay,
    input wire bcs_pkg::bcs_flags_t i_flags,
    output bcs_pkg::bcs_events_t o_events,
    output logic o_busy,
    output logic o_test_due
);
    import bcs_pkg::*;
    bcs_event_t step;
    logic [3:0] wait_cnt;

    // Trusts only the primary request; mirrors may lag
    assign o_test_due = i_flags.request;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            step <= EV_NONE;
            wait_cnt <= 4'h0;
            o_busy <= 1'b0;
            o_events <= '0;
        end else begin
            o_events <= '0;
            if (i_go) begin
                step <= i_kind;
                wait_cnt <= i_delay;
                o_busy <= 1'b1;
            end else if (o_busy && wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (o_busy) begin
                o_busy <= 1'b0;
                // One-cycle pulse, mapped into the event word order
                o_events <= {step[7], step[4], step[3], step[2], step[6],
                    step[5], step[1], step[9], step[8]};
            end
        end
    end
endmodule
